// ---- logic/sfe_top.v ----
/*
 * Erase command sequencer of a serial NOR flash: decodes erase frames,
 * checks write enable and protection, walks the array erase handshake,
 * keeps per-sector protection and erase-complete bits.
 * Assumes serial pins are asynchronous and that the array logic answers
 * each erase request with a one-cycle done pulse on the system clock.
 */
// Function
// - Uniform mode ignores both parameter erase opcodes.
// - Parameter erase sets whole 4 kB sector.
// - Erase commands accepted only with write latch set.
// - Parameter erase address three or four bytes.
// - Large erase address three or four bytes.
// - Chip select rise after address starts erase.
// - Busy bit high while erase runs.
// - Protected parameter sector erase flags error.
// - Parameter erase outside overlay ignored silently.
// - Protected large sector erase flags error.
// - Large erase keeps overlaid parameter sectors.
// - Uniform mode erases complete large sectors.
// - Whole erase needs rise after opcode.
// - Whole erase only with block protection clear.
// - Whole erase skips protected sectors, no error.
// - Evaluate sets status from the addressed sector's erase-complete bit.
// - Evaluate address three or four bytes.
// - Evaluate holds busy for evaluation time.
// - Evaluate sets write latch, clears at end.
// - Protection bits kept per physical sector.
// - Quad mode shifts four bits per edge.
`include "sfe_map.vh"

module sfe_top #(
    parameter       LARGE_SECTORS = 256,
    parameter       PARAM_SECTORS = 8,
    parameter       IDX_W         = 9,
    parameter       EVAL_NS       = `SFE_EVAL_TIME_NS,
    parameter       TMR_W         = 16
) (
    input  wire             i_sys_clk,
    input  wire             i_rst_b,
    input  wire             i_clk_en,
    input  wire             i_cs_b,
    input  wire             i_sck,
    input  wire [3:0]       i_io,
    input  wire             i_quad_instruction_mode,
    input  wire             i_uniform_sector_select,
    input  wire             i_address_length_select,
    input  wire             i_param_top,
    input  wire [2:0]       i_block_protect_bits,
    input  wire             i_prot_wr,
    input  wire [IDX_W-1:0] i_prot_idx,
    input  wire             i_persistent_protect_bit,
    input  wire             i_dynamic_protect_bit,
    input  wire             i_clear_status,
    input  wire             i_ers_done,
    output wire             o_busy_status_bit,
    output wire             o_write_latch_status_bit,
    output wire             o_erase_status_bit,
    output wire             o_erase_error,
    output wire             o_ers_req,
    output wire [IDX_W-1:0] o_ers_idx,
    output wire             o_ers_keep_param
);
    localparam integer TOTAL    = LARGE_SECTORS + PARAM_SECTORS;
    localparam integer EVAL_INT = (EVAL_NS * `SFE_CLK_MHZ + 999) / 1000;
    localparam integer TOP_INT  = LARGE_SECTORS - 1;
    localparam [TMR_W-1:0] EVAL_CYC = EVAL_INT[TMR_W-1:0];
    localparam [IDX_W-1:0] LARGE_N  = LARGE_SECTORS[IDX_W-1:0];
    localparam [IDX_W-1:0] TOTAL_N  = TOTAL[IDX_W-1:0];
    localparam [IDX_W-1:0] TOP_SECT = TOP_INT[IDX_W-1:0];
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ERASE = 3'h1;
    localparam [2:0] ST_SCAN  = 3'h2;
    localparam [2:0] ST_BWAIT = 3'h3;
    localparam [2:0] ST_EVAL  = 3'h4;

    wire        rst_sync_b;
    wire        cs_s;
    wire        sck_s;
    wire [3:0]  io_s;
    wire [39:0] shift_q;
    wire [5:0]  cnt_q;

    reg              cs_q;
    reg              sck_q;
    reg  [2:0]       state_q;
    reg              wel_q;
    reg              err_q;
    reg              ees_q;
    reg              req_q;
    reg  [IDX_W-1:0] idx_q;
    reg              keep_q;
    reg  [IDX_W-1:0] scan_q;
    reg  [TMR_W-1:0] tmr_q;
    reg  [TOTAL-1:0] ppb_q;
    reg  [TOTAL-1:0] dyb_q;
    reg  [TOTAL-1:0] ok_q;

    reg  [7:0]       op;
    reg  [31:0]      addr;
    reg  [IDX_W-1:0] tgt_idx;
    reg              in_overlay;
    reg              tgt_prot;
    reg              keep_tgt;

    sfe_sync #(.WIDTH(1), .RST_VAL(0)) u_rst_sync (
        .i_clk    (i_sys_clk),
        .i_rst_b  (i_rst_b),
        .i_clk_en (1'b1),
        .i_async  (1'b1),
        .o_sync   (rst_sync_b)
    );

    sfe_sync #(.WIDTH(6), .RST_VAL(1)) u_pin_sync (
        .i_clk    (i_sys_clk),
        .i_rst_b  (rst_sync_b),
        .i_clk_en (i_clk_en),
        .i_async  ({i_io, i_sck, i_cs_b}),
        .o_sync   ({io_s, sck_s, cs_s})
    );

    sfe_shift u_shift (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (rst_sync_b),
        .i_clk_en    (i_clk_en),
        .i_frame_clr (cs_s),
        .i_sck_rise  (sck_s & ~sck_q & ~cs_s),
        .i_quad      (i_quad_instruction_mode),
        .i_io        (io_s),
        .o_shift_q   (shift_q),
        .o_cnt_q     (cnt_q)
    );

    wire cs_rise = cs_s & ~cs_q;

    // Frame length in bits that an opcode needs with its address.
    function [5:0] frame_len;
        input [7:0] f_op;
        input       f_alen;
        begin
            if (f_op == `SFE_OP_PARAM_ERASE_4B ||
                f_op == `SFE_OP_LARGE_ERASE_4B) begin
                frame_len = `SFE_FRAME_LONG;
            end else if (f_op == `SFE_OP_PARAM_ERASE ||
                         f_op == `SFE_OP_LARGE_ERASE ||
                         f_op == `SFE_OP_EVAL_STATUS) begin
                frame_len = f_alen ? `SFE_FRAME_LONG
                                   : `SFE_FRAME_SHORT;
            end else begin
                frame_len = `SFE_OP_BITS;
            end
        end
    endfunction

    // Block protection covers an upper run of large sectors.
    function bp_hit;
        input [IDX_W-1:0] f_idx;
        input [2:0]       f_bp;
        reg   [IDX_W:0]   span;
        begin
            span   = {{IDX_W{1'b0}}, 1'b1} << ({1'b0, f_bp} + 4'h1);
            bp_hit = (f_bp != 3'h0) &&
                     ({1'b0, f_idx} + span >= {1'b0, LARGE_N});
        end
    endfunction

    always @* begin
        op = 8'h00;
        if (cnt_q == `SFE_OP_BITS) begin
            op = shift_q[7:0];
        end else if (cnt_q == `SFE_FRAME_SHORT) begin
            op = shift_q[31:24];
        end else if (cnt_q == `SFE_FRAME_LONG) begin
            op = shift_q[39:32];
        end
        addr = (cnt_q == `SFE_FRAME_SHORT) ? {8'h00, shift_q[23:0]}
                                           : shift_q[31:0];
        in_overlay = i_param_top ?
            (&addr[`SFE_LARGE_MSB:`SFE_OVERLAY_LSB]) :
            (~|addr[`SFE_LARGE_MSB:`SFE_OVERLAY_LSB]);
        tgt_idx = {{(IDX_W-8){1'b0}}, addr[`SFE_LARGE_MSB:`SFE_LARGE_LSB]};
        if (op == `SFE_OP_PARAM_ERASE || op == `SFE_OP_PARAM_ERASE_4B ||
            (op == `SFE_OP_EVAL_STATUS && in_overlay &&
             !i_uniform_sector_select)) begin
            tgt_idx = LARGE_N +
                {{(IDX_W-3){1'b0}}, addr[`SFE_PARAM_MSB:`SFE_PARAM_LSB]};
        end
        tgt_prot = bp_hit(tgt_idx >= LARGE_N ?
                              (i_param_top ? TOP_SECT : {IDX_W{1'b0}}) :
                              tgt_idx, i_block_protect_bits) |
                   ppb_q[tgt_idx] | dyb_q[tgt_idx];
        keep_tgt = !i_uniform_sector_select &&
                   (tgt_idx == (i_param_top ? TOP_SECT : {IDX_W{1'b0}}));
    end

    always @(posedge i_sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cs_q    <= 1'b1;
            sck_q   <= 1'b0;
            state_q <= ST_IDLE;
            wel_q   <= 1'b0;
            err_q   <= 1'b0;
            ees_q   <= 1'b0;
            req_q   <= 1'b0;
            idx_q   <= {IDX_W{1'b0}};
            keep_q  <= 1'b0;
            scan_q  <= {IDX_W{1'b0}};
            tmr_q   <= {TMR_W{1'b0}};
            ppb_q   <= {TOTAL{`SFE_RST_PROTECT}};
            dyb_q   <= {TOTAL{`SFE_RST_PROTECT}};
            ok_q    <= {TOTAL{`SFE_RST_ERASED_OK}};
        end else if (i_clk_en) begin
            cs_q  <= cs_s;
            sck_q <= sck_s;
            if (i_prot_wr && i_prot_idx < TOTAL_N) begin
                ppb_q[i_prot_idx] <= i_persistent_protect_bit;
                dyb_q[i_prot_idx] <= i_dynamic_protect_bit;
            end
            if (i_clear_status) begin
                err_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (cs_rise && cnt_q == frame_len(op,
                            i_address_length_select)) begin
                        if (op == `SFE_OP_WRITE_ENABLE) begin
                            wel_q <= 1'b1;
                        end else if ((op == `SFE_OP_PARAM_ERASE ||
                                      op == `SFE_OP_PARAM_ERASE_4B) &&
                                     wel_q) begin
                            wel_q <= 1'b0;
                            if (i_uniform_sector_select || !in_overlay) begin
                                // Ignored without error.
                            end else if (tgt_prot) begin
                                err_q <= 1'b1;
                            end else begin
                                wel_q   <= 1'b1;
                                req_q   <= 1'b1;
                                idx_q   <= tgt_idx;
                                keep_q  <= 1'b0;
                                ok_q[tgt_idx] <= 1'b0;
                                state_q <= ST_ERASE;
                            end
                        end else if ((op == `SFE_OP_LARGE_ERASE ||
                                      op == `SFE_OP_LARGE_ERASE_4B) &&
                                     wel_q) begin
                            if (tgt_prot) begin
                                err_q <= 1'b1;
                                wel_q <= 1'b0;
                            end else begin
                                req_q   <= 1'b1;
                                idx_q   <= tgt_idx;
                                keep_q  <= keep_tgt;
                                ok_q[tgt_idx] <= 1'b0;
                                state_q <= ST_ERASE;
                            end
                        end else if ((op == `SFE_OP_WHOLE_ERASE_A ||
                                      op == `SFE_OP_WHOLE_ERASE_B) &&
                                     wel_q) begin
                            if (i_block_protect_bits != 3'h0) begin
                                wel_q <= 1'b0;
                            end else begin
                                scan_q  <= {IDX_W{1'b0}};
                                state_q <= ST_SCAN;
                            end
                        end else if (op == `SFE_OP_EVAL_STATUS) begin
                            wel_q   <= 1'b1;
                            idx_q   <= tgt_idx;
                            tmr_q   <= EVAL_CYC;
                            state_q <= ST_EVAL;
                        end
                    end
                end
                ST_ERASE: begin
                    if (i_ers_done) begin
                        req_q   <= 1'b0;
                        ok_q[idx_q] <= 1'b1;
                        wel_q   <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_SCAN: begin
                    if (scan_q >= TOTAL_N) begin
                        wel_q   <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if ((i_uniform_sector_select &&
                                  scan_q >= LARGE_N) ||
                                 ppb_q[scan_q] || dyb_q[scan_q]) begin
                        scan_q <= scan_q + 1'b1;
                    end else begin
                        req_q   <= 1'b1;
                        idx_q   <= scan_q;
                        keep_q  <= !i_uniform_sector_select &&
                                   scan_q == (i_param_top ? TOP_SECT
                                                          : {IDX_W{1'b0}});
                        ok_q[scan_q] <= 1'b0;
                        state_q <= ST_BWAIT;
                    end
                end
                ST_BWAIT: begin
                    if (i_ers_done) begin
                        req_q   <= 1'b0;
                        ok_q[idx_q] <= 1'b1;
                        scan_q  <= scan_q + 1'b1;
                        state_q <= ST_SCAN;
                    end
                end
                ST_EVAL: begin
                    if (tmr_q <= {{(TMR_W-1){1'b0}}, 1'b1}) begin
                        ees_q   <= ok_q[idx_q];
                        wel_q   <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_busy_status_bit        = (state_q != ST_IDLE);
    assign o_write_latch_status_bit = wel_q;
    assign o_erase_status_bit       = ees_q;
    assign o_erase_error            = err_q;
    assign o_ers_req                = req_q;
    assign o_ers_idx                = idx_q;
    assign o_ers_keep_param         = keep_q;
endmodule

// ---- logic/sfe_map.vh ----
/*
 * Opcodes, frame lengths, address field positions, reset values and timing
 * for the serial flash erase sequencer.
 * Assumes that it is included by its bare name and holds definitions only.
 */
`ifndef SFE_MAP_VH
`define SFE_MAP_VH

`define SFE_OP_WRITE_ENABLE    8'h06
`define SFE_OP_PARAM_ERASE     8'h20
`define SFE_OP_PARAM_ERASE_4B  8'h21
`define SFE_OP_LARGE_ERASE     8'hd8
`define SFE_OP_LARGE_ERASE_4B  8'hdc
`define SFE_OP_WHOLE_ERASE_A   8'h60
`define SFE_OP_WHOLE_ERASE_B   8'hc7
`define SFE_OP_EVAL_STATUS     8'hd0

`define SFE_OP_BITS            6'h08
`define SFE_FRAME_SHORT        6'h20
`define SFE_FRAME_LONG         6'h28
`define SFE_CNT_MAX            6'h3f

`define SFE_LARGE_LSB          18
`define SFE_LARGE_MSB          25
`define SFE_PARAM_LSB          12
`define SFE_PARAM_MSB          14
`define SFE_OVERLAY_LSB        15

`define SFE_RST_PROTECT        1'b0
`define SFE_RST_ERASED_OK      1'b1

`define SFE_CLK_MHZ            200
`define SFE_EVAL_TIME_NS       20000

`endif

// ---- logic/sfe_sync.v ----
/*
 * Two-flop synchroniser with asynchronous reset to a fixed value.
 * Assumes the input comes from outside the clock domain of i_clk.
 */
module sfe_sync #(
    parameter       WIDTH   = 1,
    parameter       RST_VAL = 0
) (
    input  wire             i_clk,
    input  wire             i_rst_b,
    input  wire             i_clk_en,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    localparam [WIDTH-1:0] RV = RST_VAL[WIDTH-1:0];
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= RV;
            sync_q <= RV;
        end else if (i_clk_en) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// ---- logic/sfe_shift.v ----
/*
 * Serial frame shifter: collects bits on each serial clock rising edge
 * while chip select is low, one bit or four bits per edge.
 * Assumes synchronised, edge-qualified inputs on the system clock.
 */
`include "sfe_map.vh"

module sfe_shift (
    input  wire        i_sys_clk,
    input  wire        i_rst_b,
    input  wire        i_clk_en,
    input  wire        i_frame_clr,
    input  wire        i_sck_rise,
    input  wire        i_quad,
    input  wire [3:0]  i_io,
    output reg  [39:0] o_shift_q,
    output reg  [5:0]  o_cnt_q
);
    reg [5:0] step;

    always @* begin
        step = i_quad ? 6'h04 : 6'h01;
    end

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_shift_q <= 40'h0;
            o_cnt_q   <= 6'h0;
        end else if (i_clk_en) begin
            if (i_frame_clr) begin
                o_shift_q <= 40'h0;
                o_cnt_q   <= 6'h0;
            end else if (i_sck_rise) begin
                if (i_quad) begin
                    o_shift_q <= {o_shift_q[35:0], i_io};
                end else begin
                    o_shift_q <= {o_shift_q[38:0], i_io[0]};
                end
                if (o_cnt_q <= `SFE_CNT_MAX - step) begin
                    o_cnt_q <= o_cnt_q + step;
                end else begin
                    o_cnt_q <= `SFE_CNT_MAX;
                end
            end
        end
    end
endmodule

// ---- sim/sfe_top_properties.sv ----
/*
 * Checker for the erase sequencer: status, array handshake and framing.
 * Assumes it is bound to sfe_top and sees only that module's ports.
 */
module sfe_chk #(
    parameter IDX_W = 9
) (
    input wire logic             i_sys_clk,
    input wire logic             i_rst_b,
    input wire logic             i_cs_b,
    input wire logic             i_uniform_sector_select,
    input wire logic             i_ers_done,
    input wire logic             o_busy_status_bit,
    input wire logic             o_write_latch_status_bit,
    input wire logic             o_erase_status_bit,
    input wire logic             o_erase_error,
    input wire logic             o_ers_req,
    input wire logic [IDX_W-1:0] o_ers_idx,
    input wire logic             o_ers_keep_param
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    property p_req_busy;
        o_ers_req |-> o_busy_status_bit;
    endproperty
    a_req_busy: assert property (p_req_busy)
        else $error("erase request without busy");
    property p_req_hold;
        o_ers_req && !i_ers_done |=> o_ers_req && $stable(o_ers_idx)
            && $stable(o_ers_keep_param);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("erase request changed while waiting");
    property p_req_drop;
        o_ers_req && i_ers_done |=> !o_ers_req;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("erase request held after done");
    property p_start_cs;
        $rose(o_busy_status_bit) |-> $past(i_cs_b, 1) && $past(i_cs_b, 2);
    endproperty
    a_start_cs: assert property (p_start_cs)
        else $error("busy rose without chip select high");
    property p_end_wel;
        $fell(o_busy_status_bit) |-> !o_write_latch_status_bit;
    endproperty
    a_end_wel: assert property (p_end_wel)
        else $error("write latch left set after operation");
    property p_err_wel;
        $rose(o_erase_error) |-> !o_write_latch_status_bit
            && !o_busy_status_bit;
    endproperty
    a_err_wel: assert property (p_err_wel)
        else $error("error flag raised with latch or busy set");
    property p_uni_idx;
        o_ers_req && i_uniform_sector_select |-> !o_ers_idx[IDX_W-1]
            && !o_ers_keep_param;
    endproperty
    a_uni_idx: assert property (p_uni_idx)
        else $error("small sector request in uniform mode");
    property p_ees_eval;
        $changed(o_erase_status_bit) |-> $past(o_busy_status_bit)
            && !o_busy_status_bit;
    endproperty
    a_ees_eval: assert property (p_ees_eval)
        else $error("erase status changed outside evaluate end");

    c_keep: cover property ($rose(o_ers_req) && o_ers_keep_param);
    c_err:  cover property ($rose(o_erase_error));
    c_ees:  cover property ($rose(o_erase_status_bit));
endmodule

bind sfe_top sfe_chk #(.IDX_W(IDX_W)) u_sfe_chk (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b),
    .i_uniform_sector_select(i_uniform_sector_select),
    .i_ers_done(i_ers_done), .o_busy_status_bit(o_busy_status_bit),
    .o_write_latch_status_bit(o_write_latch_status_bit),
    .o_erase_status_bit(o_erase_status_bit), .o_erase_error(o_erase_error),
    .o_ers_req(o_ers_req), .o_ers_idx(o_ers_idx),
    .o_ers_keep_param(o_ers_keep_param));

// ---- sim/sfe_host.sv ----
/*
 * Serial host model: sends whole frames on chip select, clock and IO lines.
 * Assumes the sequencer samples the pins on the same system clock.
 */
module sfe_host (
    input  wire logic       i_sys_clk,
    output logic            o_cs_b,
    output logic            o_sck,
    output logic [3:0]      o_io
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_cs_b = 1'b1;
        o_sck  = 1'b0;
        o_io   = 4'h0;
    end

    // Idle lines wander so a stale bit is never mistaken for data.
    always @(posedge i_sys_clk) begin
        if (o_cs_b) begin
            o_io <= o_io + 4'h1;
        end
    end

    task frame(input logic [39:0] d, input logic [5:0] n, input logic q);
        integer i;
        @(posedge i_sys_clk);
        o_cs_b <= 1'b0;
        for (i = 0; i < (q ? n / 4 : n); i++) begin
            repeat (3) @(posedge i_sys_clk);
            o_io <= q ? d[39-4*i -: 4] : {3'h0, d[39-i]};
            repeat (3) @(posedge i_sys_clk);
            o_sck <= 1'b1;
            repeat (3) @(posedge i_sys_clk);
            o_sck <= 1'b0;
        end
        repeat (3) @(posedge i_sys_clk);
        o_cs_b <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
    endtask
endmodule

// ---- sim/serial_flash_erase_commands_tb.sv ----
/*
 * Self-checking bench for the erase sequencer with an array responder.
 * Assumes sfe_top, sfe_host and the bound checker are compiled alongside.
 */
`include "sfe_map.vh"
module serial_flash_erase_commands_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk, i_rst_b, uni, alen, prot_wr, persistent_protect_bit, dynamic_protect_bit, clr, done, req_d;
    logic        qm, ce, top;
    logic [2:0]  bp;
    logic [8:0]  pidx;
    logic [7:0]  rnd, sec;
    logic [9:0]  q_req[$];
    logic [3:0]  q_st[$];
    wire         cs_b, sck, busy, write_enable_latch, evaluate_erase_status_cmd, err, req, keep;
    wire  [3:0]  io;
    wire  [8:0]  idx;
    integer      failures, check_count, cyc, k;
    event        st_evt;

    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    sfe_host u_sfe_host (.i_sys_clk(i_sys_clk), .o_cs_b(cs_b), .o_sck(sck),
        .o_io(io));
    sfe_top #(.EVAL_NS(100)) u_sfe_top (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_clk_en(ce), .i_cs_b(cs_b), .i_sck(sck),
        .i_io(io), .i_quad_instruction_mode(qm), .i_uniform_sector_select(uni),
        .i_address_length_select(alen), .i_param_top(top),
        .i_block_protect_bits(bp), .i_prot_wr(prot_wr), .i_prot_idx(pidx),
        .i_persistent_protect_bit(persistent_protect_bit), .i_dynamic_protect_bit(dynamic_protect_bit),
        .i_clear_status(clr), .i_ers_done(done), .o_busy_status_bit(busy),
        .o_write_latch_status_bit(write_enable_latch), .o_erase_status_bit(evaluate_erase_status_cmd),
        .o_erase_error(err), .o_ers_req(req), .o_ers_idx(idx),
        .o_ers_keep_param(keep));

    function logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task check(input string nm, input logic [9:0] seen, input logic [9:0] e);
        check_count++;
        if (seen !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task final_report;
        check("requests left", 10'(q_req.size()), 10'h0);
        check("status left", 10'(q_st.size()), 10'h0);
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task st(input logic [3:0] e);
        q_st.push_back(e);
        @(negedge i_sys_clk);
        ->st_evt;
        @(negedge i_sys_clk);
    endtask
    task idle;
        repeat (8) @(posedge i_sys_clk);
        while (busy !== 1'b0) @(posedge i_sys_clk);
    endtask
    task write_enable_cmd;
        u_sfe_host.frame({`SFE_OP_WRITE_ENABLE, 32'h0}, 6'd8, 1'b0);
    endtask
    task ers(input logic [39:0] d, input logic [5:0] n);
        write_enable_cmd();
        u_sfe_host.frame(d, n, 1'b0);
        idle();
    endtask
    task prot(input logic [8:0] i, input logic p, input logic d);
        @(posedge i_sys_clk);
        pidx <= i;
        persistent_protect_bit <= p;
        dynamic_protect_bit <= d;
        prot_wr <= 1'b1;
        @(posedge i_sys_clk);
        prot_wr <= 1'b0;
    endtask
    task clear;
        @(posedge i_sys_clk);
        clr <= 1'b1;
        @(posedge i_sys_clk);
        clr <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
    endtask

    // Array responder: done pulses on the third cycle of each request.
    always @(posedge i_sys_clk) begin
        req_d <= req;
        done <= req && req_d && !done;
        if (req && !req_d) begin
            if (q_req.size() == 0) begin
                check("request", {keep, idx}, 10'h3ff);
            end else begin
                check("request", {keep, idx}, q_req.pop_front());
            end
        end
    end
    always @(st_evt) begin
        check("status", {6'h0, err, write_enable_latch, busy, evaluate_erase_status_cmd},
              {6'h0, q_st.pop_front()});
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        {i_rst_b, uni, alen, prot_wr, persistent_protect_bit, dynamic_protect_bit, clr, done, req_d, qm, top} = 0;
        ce = 1'b1;
        bp = 3'h0;
        pidx = 9'h0;
        rnd = 8'h05;
        failures = 0;
        check_count = 0;
        cyc = 0;
        repeat (20) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        st(4'h0);
        u_sfe_host.frame({`SFE_OP_LARGE_ERASE, 24'h040000, 8'h0}, 6'd32, 1'b0);
        idle();
        st(4'h0);
        q_req.push_back({1'b0, 9'd1});
        ers({`SFE_OP_LARGE_ERASE, 24'h040000, 8'h0}, 6'd32);
        st(4'h0);
        q_req.push_back({1'b1, 9'd0});
        ers({`SFE_OP_LARGE_ERASE, 32'h0}, 6'd32);
        q_req.push_back({1'b0, 9'd259});
        ers({`SFE_OP_PARAM_ERASE, 24'h003000, 8'h0}, 6'd32);
        ers({`SFE_OP_PARAM_ERASE, 24'h080000, 8'h0}, 6'd32);
        st(4'h0);
        ers({`SFE_OP_LARGE_ERASE, 24'h040000, 8'h0}, 6'd31);
        st(4'h4);
        u_sfe_host.frame({`SFE_OP_WHOLE_ERASE_A, 32'h0}, 6'd9, 1'b0);
        idle();
        st(4'h4);
        qm <= 1'b1;
        q_req.push_back({1'b0, 9'd257});
        u_sfe_host.frame({`SFE_OP_PARAM_ERASE_4B, 32'h1000}, 6'd40, 1'b1);
        idle();
        qm <= 1'b0;
        st(4'h0);
        rnd = lfsr(rnd);
        sec = rnd | 8'h10;
        alen <= 1'b1;
        q_req.push_back({2'b00, sec});
        ers({`SFE_OP_LARGE_ERASE, 6'h0, sec, 18'h0}, 6'd40);
        alen <= 1'b0;
        prot(9'd5, 1'b0, 1'b1);
        ers({`SFE_OP_LARGE_ERASE_4B, 32'h00140000}, 6'd40);
        st(4'h8);
        clear();
        prot(9'd258, 1'b1, 1'b0);
        ers({`SFE_OP_PARAM_ERASE, 24'h002000, 8'h0}, 6'd32);
        st(4'h8);
        clear();
        top <= 1'b1;
        q_req.push_back({1'b1, 9'd255});
        ers({`SFE_OP_LARGE_ERASE_4B, 32'h03fc0000}, 6'd40);
        top <= 1'b0;
        uni <= 1'b1;
        ers({`SFE_OP_PARAM_ERASE, 24'h003000, 8'h0}, 6'd32);
        st(4'h0);
        q_req.push_back({1'b0, 9'd0});
        ers({`SFE_OP_LARGE_ERASE, 32'h0}, 6'd32);
        bp <= 3'h1;
        ers({`SFE_OP_WHOLE_ERASE_A, 32'h0}, 6'd8);
        st(4'h0);
        bp <= 3'h0;
        for (k = 0; k < 256; k++) if (k != 5) q_req.push_back(k[9:0]);
        ers({`SFE_OP_WHOLE_ERASE_B, 32'h0}, 6'd8);
        st(4'h0);
        alen <= 1'b1;
        u_sfe_host.frame({`SFE_OP_EVAL_STATUS, 32'h00040000}, 6'd40, 1'b0);
        repeat (2) @(posedge i_sys_clk);
        st(4'h6);
        ce <= 1'b0;
        repeat (30) @(posedge i_sys_clk);
        st(4'h6);
        ce <= 1'b1;
        idle();
        st(4'h1);
        if (evaluate_erase_status_cmd !== 1'b1) begin
            ers({`SFE_OP_LARGE_ERASE, 32'h00040000}, 6'd40);
        end
        final_report();
    end
endmodule
